// *** include/spi_slave_pkg.sv ***
package spi_slave_pkg;

    // ****************************************************************
    // Widths
    // ****************************************************************
    localparam int unsigned ADDR_W  = 8;
    localparam int unsigned DATA_W  = 32;
    localparam int unsigned ROUTE_W = 16;
    localparam int unsigned PIN_W   = 8;

    // ****************************************************************
    // Register byte addresses
    // ****************************************************************
    localparam logic [7:0] OFF_FUNC     = 8'h00;
    localparam logic [7:0] OFF_IN_ROUTE = 8'h04;
    localparam logic [7:0] OFF_OUT_ROUTE = 8'h08;
    localparam logic [7:0] OFF_SHIFT    = 8'h0c;
    localparam logic [7:0] OFF_TX       = 8'h10;
    localparam logic [7:0] OFF_RX       = 8'h14;
    localparam logic [7:0] OFF_CTRL     = 8'h18;
    localparam logic [7:0] OFF_IRQ_STAT = 8'h1c;
    localparam logic [7:0] OFF_IRQ_MASK = 8'h20;

    // ****************************************************************
    // Values
    // ****************************************************************
    localparam logic [7:0] FUNC_PATTERN    = 8'h0e;
    localparam logic [7:0] IN_ROUTE_RESET  = 8'h10;
    localparam logic [7:0] OUT_ROUTE_RESET = 8'h10;
    localparam logic [7:0] CTRL_RESET      = 8'h00;
    localparam logic [7:0] MODE_MASK       = 8'h06;
    localparam logic [7:0] MODE_1          = 8'h02;
    localparam logic [7:0] MODE_2          = 8'h04;
    localparam logic [7:0] MODE_3          = 8'h06;
    localparam logic [2:0] BIT_LAST        = 3'h7;
    localparam logic [1:0] SYNC_PLAIN      = 2'h0;

    // ****************************************************************
    // Field layouts
    // ****************************************************************
    typedef struct packed {
        logic lsb_first;
        logic rx_overrun;
        logic xfer_done;
        logic tx_empty;
        logic rx_full;
        logic clk_phase;
        logic clk_polarity;
        logic unit_enable;
    } ctrl_t;

    typedef struct packed {
        logic [3:0] mosi_src;
        logic [3:0] sclk_src;
    } in_route_t;

    typedef struct packed {
        logic       zero;
        logic [1:0] clock_sync_select;
        logic [1:0] ss_src;
        logic [2:0] miso_dst;
    } out_route_t;

    typedef struct packed {
        logic rx_overrun;
        logic xfer_done;
        logic tx_empty;
        logic rx_full;
    } events_t;

    typedef enum logic {link_idle, link_busy} link_state_t;

endpackage

// *** logic/spi_slave_byte_port.sv ***
// The APB slave port and the register offsets were decided locally.
`timescale 1ns/10ps
// How it works
// - Slave logic runs only while the function register holds 8'h0e.
// - Input routing picks master data source (7:4) and serial clock source (3:0).
// - Output routing reads bit 7 zero; then sync select, select source, data pin.
// - An 8-bit shift register moves one bit in and one out per serial clock cycle.
// - When enabled, a written transmit byte moves into the shift register.
// - A finished byte is copied from the shift register to the receive buffer.
// - Control bit 7 set sends and receives least significant bit first.
// - Status bit 6 flags a new byte arriving before the old one was read.
// - Status bit 5 flags a finished 8-bit exchange and may interrupt.
// - Status bit 4 flags transmit buffer emptied into the shift register.
// - Status bit 3 flags a received byte waiting in the receive buffer.
// - Control bit 2 is clock phase, bit 1 clock polarity; master must match.
// - Control bit 0 enables; when clear nothing shifts, and only a bus write loads the shift register.
// - Reading the control register clears those of its four status flags that the read returned set.
// - Mode values: 8'h02 polarity only, 8'h04 phase only, 8'h06 both.
module spi_slave_byte_port
    import spi_slave_pkg::*;
(
    input  wire logic                               clock,
    input  wire logic                               rst,
    input  wire logic [spi_slave_pkg::ADDR_W-1:0]   paddr,
    input  wire logic                               psel,
    input  wire logic                               penable,
    input  wire logic                               pwrite,
    input  wire logic [spi_slave_pkg::DATA_W-1:0]   pwdata,
    output logic      [spi_slave_pkg::DATA_W-1:0]   prdata,
    output logic                                    pready,
    output logic                                    pslverr,
    input  wire logic [spi_slave_pkg::ROUTE_W-1:0]  route_in,
    output logic      [spi_slave_pkg::PIN_W-1:0]    miso_out,
    output logic                                    irq
);
    import spi_slave_pkg::*;

    // ****************************************************************
    // Declarations
    // ****************************************************************
    logic [7:0]          func_r;
    in_route_t           in_r;
    out_route_t          out_r;
    ctrl_t               ctrl_r;
    logic [7:0]          shift_r;
    logic [7:0]          tx_r;
    logic [7:0]          rx_r;
    logic                tx_full_r;
    logic                rx_unread_r;
    events_t             irq_stat_r;
    events_t             irq_mask_r;
    logic [DATA_W-1:0]   prdata_r;
    logic                pready_r;
    logic                pslverr_r;
    logic [7:0]          rd_capture_r;
    logic [ROUTE_W-1:0]  route_s1_r;
    logic [ROUTE_W-1:0]  route_s2_r;
    logic                sclk_stage_r;
    logic                sclk_lvl_r;
    logic                sclk_prev_r;
    logic [2:0]          bit_cnt_r;
    logic                pend_r;
    logic                samp_r;
    link_state_t         link_st_r;
    logic [PIN_W-1:0]    miso_r;
    logic                irq_r;

    logic                access;
    logic                wr_acc;
    logic                rd_acc;
    logic                func_ok;
    logic                mosi_lvl;
    logic                sclk_raw;
    logic                ss_n_lvl;
    logic                active;
    logic                rise_raw;
    logic                fall_raw;
    logic                lead_edge;
    logic                trail_edge;
    logic                samp_edge;
    logic                chg_edge;
    logic                byte_done;
    logic                tx_load;
    logic [7:0]          full_byte;
    logic                out_bit;
    logic                ctrl_rd;
    events_t             ev_set;
    events_t             ev_clr;
    logic [DATA_W-1:0]   rd_word;
    logic                rd_bad;

    // Shift one bit into a byte in the selected order
    function automatic logic [7:0] shift_in(input logic [7:0] b, input logic d,
                                            input logic lsb);
        shift_in = lsb ? {d, b[7:1]} : {b[6:0], d};
    endfunction

    // ****************************************************************
    // APB slave
    // ****************************************************************

    // Transfer qualifiers; one wait-free access phase after setup
    assign access = psel & penable & pready_r;
    assign wr_acc = access & pwrite;
    assign rd_acc = access & ~pwrite;
    assign ctrl_rd = rd_acc & (paddr == OFF_CTRL);

    // Read mux, narrow registers in the low byte
    always_comb begin
        rd_word = '0;
        rd_bad  = 1'b0;
        case (paddr)
            OFF_FUNC:      rd_word[7:0] = func_r;
            OFF_IN_ROUTE:  rd_word[7:0] = in_r;
            OFF_OUT_ROUTE: rd_word[7:0] = {1'b0, out_r[6:0]};
            OFF_SHIFT:     rd_word[7:0] = shift_r;
            OFF_TX:        rd_word[7:0] = 8'h00;
            OFF_RX:        rd_word[7:0] = rx_r;
            OFF_CTRL:      rd_word[7:0] = ctrl_r;
            OFF_IRQ_STAT:  rd_word[3:0] = irq_stat_r;
            OFF_IRQ_MASK:  rd_word[3:0] = irq_mask_r;
            default:       rd_bad = 1'b1;
        endcase
    end

    // Answer is prepared during setup and presented in the access phase
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            pready_r     <= 1'b0;
            prdata_r     <= '0;
            pslverr_r    <= 1'b0;
            rd_capture_r <= 8'h00;
        end else if (psel & ~penable & ~pready_r) begin
            pready_r     <= 1'b1;
            prdata_r     <= pwrite ? '0 : rd_word;
            pslverr_r    <= rd_bad;
            rd_capture_r <= rd_word[7:0];
        end else begin
            pready_r  <= 1'b0;
            pslverr_r <= 1'b0;
        end
    end

    // Configuration registers
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            func_r <= FUNC_PATTERN;
            in_r   <= IN_ROUTE_RESET;
            out_r  <= OUT_ROUTE_RESET;
        end else if (wr_acc) begin
            if (paddr == OFF_FUNC)
                func_r <= pwdata[7:0];
            if (paddr == OFF_IN_ROUTE)
                in_r <= pwdata[7:0];
            if (paddr == OFF_OUT_ROUTE)
                out_r <= {1'b0, pwdata[6:0]};
        end
    end

    // Control bits by bus write; sticky flags in the same word, set wins over clear
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            ctrl_r <= CTRL_RESET;
        end else begin
            if (wr_acc && paddr == OFF_CTRL) begin
                ctrl_r.lsb_first    <= pwdata[7];
                ctrl_r.clk_phase    <= pwdata[2];
                ctrl_r.clk_polarity <= pwdata[1];
                ctrl_r.unit_enable  <= pwdata[0];
            end
            ctrl_r.rx_overrun <= ev_set.rx_overrun | (ctrl_r.rx_overrun & ~ev_clr.rx_overrun);
            ctrl_r.xfer_done  <= ev_set.xfer_done | (ctrl_r.xfer_done & ~ev_clr.xfer_done);
            ctrl_r.tx_empty   <= ev_set.tx_empty | (ctrl_r.tx_empty & ~ev_clr.tx_empty);
            ctrl_r.rx_full    <= ev_set.rx_full | (ctrl_r.rx_full & ~ev_clr.rx_full);
        end
    end

    // ****************************************************************
    // Pin sampling and clock edge detection
    // ****************************************************************

    // Two-flop synchroniser for all routable inputs
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            route_s1_r <= '0;
            route_s2_r <= '0;
        end else begin
            route_s1_r <= route_in;
            route_s2_r <= route_s1_r;
        end
    end

    // Source selection from the synchronised pins
    assign mosi_lvl = route_s2_r[in_r.mosi_src];
    assign sclk_raw = route_s2_r[in_r.sclk_src];
    assign ss_n_lvl = route_s2_r[{2'h0, out_r.ss_src}];

    // Clock filter: nonzero sync select needs two equal samples
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            sclk_stage_r <= 1'b0;
            sclk_lvl_r   <= 1'b0;
            sclk_prev_r  <= 1'b0;
        end else begin
            sclk_stage_r <= sclk_raw;
            if (out_r.clock_sync_select == SYNC_PLAIN || sclk_raw == sclk_stage_r)
                sclk_lvl_r <= sclk_raw;
            sclk_prev_r <= sclk_lvl_r;
        end
    end

    // Leading and trailing edges follow polarity, sampling follows phase
    assign rise_raw   = sclk_lvl_r & ~sclk_prev_r;
    assign fall_raw   = ~sclk_lvl_r & sclk_prev_r;
    assign lead_edge  = ctrl_r.clk_polarity ? fall_raw : rise_raw;
    assign trail_edge = ctrl_r.clk_polarity ? rise_raw : fall_raw;
    assign samp_edge  = ctrl_r.clk_phase ? trail_edge : lead_edge;
    assign chg_edge   = ctrl_r.clk_phase ? lead_edge : trail_edge;

    // ****************************************************************
    // Shift engine
    // ****************************************************************
    assign func_ok   = (func_r == FUNC_PATTERN);
    assign active    = ctrl_r.unit_enable & func_ok & ~ss_n_lvl;
    assign byte_done = active & samp_edge & (bit_cnt_r == BIT_LAST);
    assign full_byte = shift_in(shift_r, mosi_lvl, ctrl_r.lsb_first);
    assign tx_load   = ctrl_r.unit_enable & func_ok & tx_full_r &
                       ((link_st_r == link_idle & ~(active & samp_edge)) | byte_done);
    assign out_bit   = ctrl_r.lsb_first ? shift_r[0] : shift_r[7];

    // Bit counter, held sample and link state
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            bit_cnt_r <= 3'h0;
            pend_r    <= 1'b0;
            samp_r    <= 1'b0;
            link_st_r <= link_idle;
        end else if (!active) begin
            bit_cnt_r <= 3'h0;
            pend_r    <= 1'b0;
            link_st_r <= link_idle;
        end else if (samp_edge) begin
            bit_cnt_r <= bit_cnt_r + 3'h1;
            samp_r    <= mosi_lvl;
            pend_r    <= (bit_cnt_r != BIT_LAST);
            link_st_r <= (bit_cnt_r == BIT_LAST) ? link_idle : link_busy;
        end else if (chg_edge) begin
            pend_r <= 1'b0;
        end
    end

    // Shift register: bus write while disabled, load, finish, shift
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            shift_r <= 8'h00;
        end else if (wr_acc && paddr == OFF_SHIFT && !ctrl_r.unit_enable) begin
            shift_r <= pwdata[7:0];
        end else if (tx_load) begin
            shift_r <= tx_r;
        end else if (byte_done) begin
            shift_r <= full_byte;
        end else if (active && chg_edge && pend_r) begin
            shift_r <= shift_in(shift_r, samp_r, ctrl_r.lsb_first);
        end
    end

    // Transmit buffer
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            tx_r      <= 8'h00;
            tx_full_r <= 1'b0;
        end else if (wr_acc && paddr == OFF_TX) begin
            tx_r      <= pwdata[7:0];
            tx_full_r <= 1'b1;
        end else if (tx_load) begin
            tx_full_r <= 1'b0;
        end
    end

    // Receive buffer; a new byte wins over a read in the same cycle
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            rx_r        <= 8'h00;
            rx_unread_r <= 1'b0;
        end else if (byte_done) begin
            rx_r        <= full_byte;
            rx_unread_r <= 1'b1;
        end else if (rd_acc && paddr == OFF_RX) begin
            rx_unread_r <= 1'b0;
        end
    end

    // ****************************************************************
    // Status flags and interrupt
    // ****************************************************************

    // Events from the shift engine
    always_comb begin
        ev_set.rx_overrun = byte_done & rx_unread_r;
        ev_set.xfer_done  = byte_done;
        ev_set.tx_empty   = tx_load;
        ev_set.rx_full    = byte_done;
    end

    // Reading control clears only the flags that the read returned
    always_comb begin
        ev_clr.rx_overrun = ctrl_rd & rd_capture_r[6];
        ev_clr.xfer_done  = ctrl_rd & rd_capture_r[5];
        ev_clr.tx_empty   = ctrl_rd & rd_capture_r[4];
        ev_clr.rx_full    = (ctrl_rd & rd_capture_r[3]) | (rd_acc & paddr == OFF_RX);
    end

    // Interrupt status, write one to clear, and mask
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            irq_stat_r <= '0;
            irq_mask_r <= '0;
        end else begin
            if (wr_acc && paddr == OFF_IRQ_STAT)
                irq_stat_r <= ev_set | (irq_stat_r & ~events_t'(pwdata[3:0]));
            else
                irq_stat_r <= ev_set | irq_stat_r;
            if (wr_acc && paddr == OFF_IRQ_MASK)
                irq_mask_r <= pwdata[3:0];
        end
    end

    // Level interrupt
    always_ff @(posedge clock or posedge rst) begin
        if (rst)
            irq_r <= 1'b0;
        else
            irq_r <= |(irq_stat_r & irq_mask_r);
    end

    // Data pin, always driven; unselected pins stay low
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            miso_r <= '0;
        end else begin
            miso_r                 <= '0;
            miso_r[out_r.miso_dst] <= out_bit;
        end
    end

    assign prdata   = prdata_r;
    assign pready   = pready_r;
    assign pslverr  = pslverr_r;
    assign miso_out = miso_r;
    assign irq      = irq_r;

    // ****************************************************************
    // Assertions
    // ****************************************************************
    default clocking cb @(posedge clock); endclocking
    default disable iff (rst);

    func_gate_a: assert property (func_r != FUNC_PATTERN |=> bit_cnt_r == 3'h0)
        else $error("slave counted bits with wrong function pattern");
    mosi_route_a: assert property (active && samp_edge |=> samp_r == $past(mosi_lvl))
        else $error("sampled bit differs from routed data input");
    out_zero_a: assert property (rd_acc && paddr == OFF_OUT_ROUTE |-> prdata_r[7] == 1'b0)
        else $error("output routing bit 7 read nonzero");
    pin_only_a: assert property (1'b1 |=> (miso_r & ~(8'h01 << $past(out_r.miso_dst))) == 8'h00)
        else $error("unselected data pin driven high");
    rx_copy_a: assert property (byte_done |=> rx_r == $past(full_byte) && ctrl_r.rx_full)
        else $error("finished byte not copied to receive buffer");
    lsb_order_a: assert property (byte_done && ctrl_r.lsb_first |=> rx_r[7] == $past(mosi_lvl))
        else $error("last bit not placed at top in lsb first order");
    msb_order_a: assert property (byte_done && !ctrl_r.lsb_first |=> rx_r[0] == $past(mosi_lvl))
        else $error("last bit not placed at bottom in msb first order");
    overrun_a: assert property (byte_done && rx_unread_r |=> ctrl_r.rx_overrun)
        else $error("overrun not flagged");
    done_irq_a: assert property (byte_done && irq_mask_r.xfer_done |=> ##1 irq_r)
        else $error("done interrupt not raised within two cycles");
    tx_move_a: assert property (tx_load |=> !tx_full_r && ctrl_r.tx_empty && shift_r == $past(tx_r))
        else $error("transmit byte not moved or flag missing");
    disabled_a: assert property (!ctrl_r.unit_enable && !(wr_acc && paddr == OFF_TX)
                                 |=> tx_full_r == $past(tx_full_r) && bit_cnt_r == 3'h0)
        else $error("disabled unit moved data");
    read_clear_a: assert property (ctrl_rd && rd_capture_r[5] && !byte_done |=> !ctrl_r.xfer_done)
        else $error("control read did not clear done flag");

    mode3_c: cover property ((ctrl_r & MODE_MASK) == MODE_3 && byte_done);
    mode1_c: cover property ((ctrl_r & MODE_MASK) == MODE_1 && byte_done);
    overrun_c: cover property (ev_set.rx_overrun);
    echo_c: cover property (byte_done ##[1:200] tx_load);

endmodule

// *** verif/spi_master_model.sv ***
`timescale 1ns/10ps
// ****
// Serial master model on route_in
// ****
module spi_master_model (
    input  wire logic        clock,
    output logic      [15:0] route_in,
    input  wire logic [7:0]  miso_out
);
    // Select high, clock and data low at rest
    initial route_in = 16'h0004;
    // Idle level of the serial clock
    task automatic park(input logic cpol);
        route_in[0] <= cpol;
    endtask
    // One byte: eight clock cycles under select
    task automatic xfer(input logic [7:0] tx, input logic cpol, cpha, lsb,
                        output logic [7:0] rx);
        logic s;
        route_in[2] <= 1'b0;
        for (int i = 0; i < 8; i++) begin
            if (!cpha)
                route_in[1] <= lsb ? tx[i] : tx[7-i];
            repeat (6) @(posedge clock);
            s = miso_out[0];
            route_in[0] <= ~cpol;
            if (cpha)
                route_in[1] <= lsb ? tx[i] : tx[7-i];
            repeat (6) @(posedge clock);
            if (cpha)
                s = miso_out[0];
            route_in[0] <= cpol;
            rx[lsb ? i : 7 - i] = s;
        end
        repeat (6) @(posedge clock);
        route_in[2] <= 1'b1;
        route_in[1] <= ~route_in[1]; // Released line shows the inverse
    endtask
endmodule

// *** verif/test_spi_slave_byte_port.sv ***
`timescale 1ns/10ps
// ****
// Bench top
// ****
module test_spi_slave_byte_port;
    import spi_slave_pkg::*;
    logic        clock;
    logic        rst;
    logic [7:0]  paddr;
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [31:0] pwdata;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic [15:0] route_in;
    logic [7:0]  miso_out;
    logic        irq;
    logic [32:0] exp_q[$];
    int          n_mismatch;
    int          tests_run;
    spi_slave_byte_port spi_slave_byte_port_inst (.clock(clock), .rst(rst), .paddr(paddr),
        .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .route_in(route_in), .miso_out(miso_out), .irq(irq));
    spi_master_model spi_master_model_inst (.clock(clock), .route_in(route_in),
        .miso_out(miso_out));
    // Compare and count
    task automatic check(input logic [32:0] seen, input logic [32:0] exp);
        tests_run++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    // Verdict and end of run
    task automatic report_and_stop();
        $display("Counts: %0d compared, %0d mismatched", tests_run, n_mismatch);
        if (n_mismatch == 0 && tests_run > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    // One bus transfer, bounded wait on pready
    task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d);
        int n;
        n = 0;
        psel <= 1'b1;
        paddr <= a;
        pwrite <= w;
        pwdata <= d;
        @(posedge clock);
        penable <= 1'b1;
        do begin
            @(posedge clock);
            n++;
        end while (pready !== 1'b1 && n < 64);
        if (n >= 64) begin
            n_mismatch++;
            report_and_stop();
        end
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clock);
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        apb(a, 1'b1, {24'h0, d});
    endtask
    // Note the expected answer, then read
    task automatic rd(input logic [7:0] a, input logic [32:0] e);
        exp_q.push_back(e);
        apb(a, 1'b0, 32'h0);
    endtask
    // Read answers against the oldest note
    always @(posedge clock) begin
        if (pready === 1'b1 && pwrite === 1'b0)
            check({pslverr, prdata}, exp_q.pop_front());
    end
    initial begin
        clock = 1'b0;
        forever #2 clock = ~clock;
    end
    // Hang guard
    initial begin
        #300000;
        n_mismatch++;
        report_and_stop();
    end
    initial begin
        logic [7:0] tx, mtx, mtx2, got, ctrl;
        rst = 1'b1;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
        n_mismatch = 0;
        tests_run = 0;
        void'($urandom(34030));
        repeat (20) @(posedge clock);
        rst <= 1'b0;
        @(posedge clock);
        rd(OFF_FUNC, {25'h0, FUNC_PATTERN});
        rd(OFF_IN_ROUTE, 33'h10);
        wr(OFF_IN_ROUTE, 8'h32);
        rd(OFF_IN_ROUTE, 33'h32);
        wr(OFF_IN_ROUTE, 8'h10);
        wr(OFF_OUT_ROUTE, 8'h90);
        rd(OFF_OUT_ROUTE, 33'h10);
        rd(8'h24, {1'b1, 32'h0});
        wr(OFF_FUNC, 8'h00);
        rd(OFF_FUNC, 33'h0);
        wr(OFF_CTRL, 8'h01);
        spi_master_model_inst.xfer(8'h5a, 1'b0, 1'b0, 1'b0, got);
        check({25'h0, got}, 33'h0);
        rd(OFF_CTRL, 33'h01);
        wr(OFF_FUNC, FUNC_PATTERN);
        $display("Register test done");
        for (int m = 0; m < 4; m++) begin
            tx = 8'($urandom);
            mtx = 8'($urandom);
            mtx2 = 8'($urandom);
            ctrl = {m[1] ^ m[0], 4'h0, m[1], m[0], 1'b1};
            wr(OFF_CTRL, 8'h00);
            wr(OFF_IRQ_MASK, {5'h0, m[0], 2'h0});
            spi_master_model_inst.park(m[0]);
            wr(OFF_SHIFT, mtx2);
            wr(OFF_TX, tx);
            rd(OFF_SHIFT, {25'h0, mtx2});
            wr(OFF_CTRL, ctrl);
            rd(OFF_CTRL, {25'h0, ctrl | 8'h10});
            rd(OFF_SHIFT, {25'h0, tx});
            spi_master_model_inst.xfer(mtx, m[0], m[1], m[1] ^ m[0], got);
            check({25'h0, got}, {25'h0, tx});
            repeat (4) @(posedge clock);
            check({32'h0, irq}, {32'h0, m[0]});
            wr(OFF_IRQ_STAT, 8'h0f);
            @(posedge clock);
            check({32'h0, irq}, 33'h0);
            rd(OFF_CTRL, {25'h0, ctrl | 8'h28});
            spi_master_model_inst.xfer(mtx2, m[0], m[1], m[1] ^ m[0], got);
            check({25'h0, got}, {25'h0, mtx});
            repeat (4) @(posedge clock);
            rd(OFF_CTRL, {25'h0, ctrl | 8'h68});
            rd(OFF_RX, {25'h0, mtx2});
            rd(OFF_TX, 33'h0);
            $display("Mode %0d test done", m);
        end
        report_and_stop();
    end
endmodule
